// ### core/isf_pkg.sv
`default_nettype none

package isf_pkg;

    // -------------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------------
    localparam logic [7:0] ISF_IDX_CTRL = 8'hf0;
    localparam logic [7:0] ISF_IDX_SR1  = 8'hf1;
    localparam logic [7:0] ISF_IDX_SR2  = 8'hf2;
    localparam logic [7:0] ISF_IDX_DATA = 8'hf6;

    localparam logic [1:0] ISF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ISF_RESP_SLVERR = 2'h2;

    // -------------------------------------------------------------------------
    // Register layouts, most significant bit first
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic       event_pending;
        logic       ten_bit_header_sent;
        logic       sending_side;
        logic       bus_busy;
        logic       byte_done;
        logic       slave_addr_match;
        logic       master_active;
        logic       start_sent;
    } isf_sr1_type;

    typedef struct packed {
        logic [1:0] zero;
        logic       addr_acked_master;
        logic       ack_failure;
        logic       stop_seen;
        logic       arb_lost;
        logic       bus_error;
        logic       general_call_hit;
    } isf_sr2_type;

    typedef struct packed {
        logic [1:0] zero;
        logic       unit_on;
        logic       general_call_enable;
        logic       start_req;
        logic       ack_enable;
        logic       stop_req;
        logic       irq_enable;
    } isf_ctrl_type;

    // Byte-level events from the shift engine, same clock
    typedef struct packed {
        logic       byte_done_tx;
        logic       byte_done_rx;
        logic       addr_match;
        logic       gc_match;
        logic       start_gen;
        logic       header_sent;
        logic       addr_acked;
        logic       no_ack;
        logic       arb_lost;
        logic       dma_done;
        logic       after_ack;
        logic       in_byte;
        logic       ack_phase;
        logic [7:0] rx_byte;
    } isf_eng_type;

endpackage : isf_pkg

`default_nettype wire

// ### core/isf_status.sv
// Summary of operation
// [R1] Event flag set by events, cleared when all clear
// [R2] Listed flags all feed the event flag
// [R3] Header flag: set on header, two-step clear
// [R4] Direction flag follows transmit byte, clears with it
// [R5] Busy tracks Start/Stop even when disabled
// [R6] Transmit byte_done: read then data write clears
// [R7] Receive byte_done needs ack; read then data read
// [R8] SCL held low while byte_done set
// [R9] Address match holds SCL, status-one read clears
// [R10] Master flag: set on Start, cleared Stop/arbitration
// [R11] Start flag holds SCL, two-step clear with write
// [R12] Flag set during clearing read raises no request
// [R13] Status-two top bits always read zero
// [R14] Address acknowledged in master mode sets flag
// [R15] Ack failure: no stretch, read after SCL fall clears
// [R16] Stop after ack as slave sets flag
// [R17] Arbitration loss sets flag, returns to slave
// [R18] Start/Stop inside byte sets bus error
// [R19] Misplaced Start adds arb loss; Stop on ack adds failure
// [R20] General call hit needs enable, cleared by Stop
// [R21] Disable clears all flags except busy
// [R22] Status-one read arms marker for data access
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none

module isf_status
    import isf_pkg::*;
#(
    parameter int AXI_AW = 12
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [AXI_AW-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire isf_pkg::isf_eng_type eng_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      scl_o,
    output logic                      scl_oe_n_o,
    output isf_pkg::isf_ctrl_type     ctrl_o,
    output logic [7:0]                tx_data_o,
    output logic                      tx_load_o,
    output logic                      event_req_o
);
    import isf_pkg::*;

    // -------------------------------------------------------------------------
    // Parameter check
    // -------------------------------------------------------------------------
    // Index 8'hf6 times four needs ten address bits
    if (AXI_AW < 10 || AXI_AW > 32) begin : gen_aw_check
        $error("isf_status: AXI_AW must lie in 10..32");
    end

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic         scl_s1;
        logic         scl_s2;
        logic         scl_d;
        logic         sda_s1;
        logic         sda_s2;
        logic         sda_d;
        isf_sr1_type  sr1;
        isf_sr2_type  sr2;
        isf_ctrl_type ctrl;
        logic         rd1_armed;
        logic         bd_tx;
        logic         af_fall_ok;
        logic [7:0]   tx_data;
        logic         tx_load;
        logic         event_req;
        logic         scl_oe_n;
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [1:0]   rresp;
        logic [31:0]  rdata;
    } isf_state_type;

    isf_state_type st_ff;
    isf_state_type nxt_st;

    logic              start_det;
    logic              stop_det;
    logic              scl_fall;
    logic              wr_go;
    logic              rd_go;
    logic [AXI_AW-3:0] wa;
    logic [AXI_AW-3:0] ra;
    logic              wr_hit;
    logic              rd_hit;
    logic              wr_cr;
    logic              wr_dr;
    logic              rd_sr1;
    logic              rd_sr2;
    logic              rd_dr;
    logic [7:0]        rbyte;
    isf_sr1_type       set1;
    isf_sr1_type       clr1;
    isf_sr2_type       set2;
    isf_sr2_type       clr2;

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Pins pass two flops; edges are judged on the second and third
        nxt_st.scl_s1 = scl_i;
        nxt_st.scl_s2 = st_ff.scl_s1;
        nxt_st.scl_d  = st_ff.scl_s2;
        nxt_st.sda_s1 = sda_i;
        nxt_st.sda_s2 = st_ff.sda_s1;
        nxt_st.sda_d  = st_ff.sda_s2;
        start_det = st_ff.sda_d & ~st_ff.sda_s2 & st_ff.scl_s2 & st_ff.scl_d;
        stop_det  = ~st_ff.sda_d & st_ff.sda_s2 & st_ff.scl_s2 & st_ff.scl_d;
        scl_fall  = st_ff.scl_d & ~st_ff.scl_s2;

        // Bus decode; a handshake completes on the edge after ready rises
        wr_go  = s_axi_awvalid & st_ff.awready & s_axi_wvalid & st_ff.wready;
        rd_go  = s_axi_arvalid & st_ff.arready;
        wa     = s_axi_awaddr[AXI_AW-1:2];
        ra     = s_axi_araddr[AXI_AW-1:2];
        wr_cr  = wr_go && wa == (AXI_AW-2)'(ISF_IDX_CTRL);
        wr_dr  = wr_go && wa == (AXI_AW-2)'(ISF_IDX_DATA) && s_axi_wstrb[0];
        wr_hit = wr_go && (wa == (AXI_AW-2)'(ISF_IDX_CTRL) || wa == (AXI_AW-2)'(ISF_IDX_SR1)
                 || wa == (AXI_AW-2)'(ISF_IDX_SR2) || wa == (AXI_AW-2)'(ISF_IDX_DATA));
        rd_sr1 = rd_go && ra == (AXI_AW-2)'(ISF_IDX_SR1);
        rd_sr2 = rd_go && ra == (AXI_AW-2)'(ISF_IDX_SR2);
        rd_dr  = rd_go && ra == (AXI_AW-2)'(ISF_IDX_DATA);
        rd_hit = rd_sr1 | rd_sr2 | rd_dr | (rd_go && ra == (AXI_AW-2)'(ISF_IDX_CTRL));

        // Flag sets, only while the unit is on
        set1 = '0;
        set2 = '0;
        if (st_ff.ctrl.unit_on) begin
            set1.byte_done           = eng_i.byte_done_tx
                                     | (eng_i.byte_done_rx & st_ff.ctrl.ack_enable); // R6 R7
            set1.sending_side        = eng_i.byte_done_tx;                       // R4
            set1.slave_addr_match    = eng_i.addr_match
                                     | (eng_i.gc_match & st_ff.ctrl.general_call_enable); // R9
            set1.master_active       = eng_i.start_gen;                          // R10
            set1.start_sent          = eng_i.start_gen;                          // R11
            set1.ten_bit_header_sent = eng_i.header_sent;                        // R3
            set2.addr_acked_master   = eng_i.addr_acked & st_ff.sr1.master_active; // R14
            set2.ack_failure         = eng_i.no_ack | (stop_det & eng_i.in_byte
                                     & eng_i.ack_phase);                         // R15 R19
            set2.stop_seen           = stop_det & ~st_ff.sr1.master_active
                                     & eng_i.after_ack;                          // R16
            set2.arb_lost            = eng_i.arb_lost | (start_det & eng_i.in_byte); // R17 R19
            set2.bus_error           = (start_det | stop_det) & eng_i.in_byte;   // R18
            set2.general_call_hit    = eng_i.gc_match
                                     & st_ff.ctrl.general_call_enable;           // R20
        end

        // Clears; a set in the same cycle wins below
        clr1 = '0;
        clr2 = '0;
        clr1.byte_done           = eng_i.dma_done | (st_ff.rd1_armed
                                 & (st_ff.bd_tx ? wr_dr : rd_dr));               // R6 R7 R22
        clr1.sending_side        = clr1.byte_done | set2.stop_seen | set2.arb_lost; // R4
        clr1.start_sent          = st_ff.rd1_armed & wr_dr;                      // R11 R22
        clr1.ten_bit_header_sent = (st_ff.rd1_armed & wr_dr) | set2.stop_seen;   // R3
        clr1.slave_addr_match    = rd_sr1;                                       // R9
        clr1.master_active       = stop_det | set2.arb_lost;                     // R10 R17
        clr2.addr_acked_master   = rd_sr2;
        clr2.ack_failure         = rd_sr2 & st_ff.af_fall_ok;                    // R15
        clr2.stop_seen           = rd_sr2;                                       // R16
        clr2.arb_lost            = rd_sr2;                                       // R17
        clr2.bus_error           = rd_sr2;                                       // R18
        clr2.general_call_hit    = stop_det;                                     // R20
        nxt_st.sr1 = isf_sr1_type'((st_ff.sr1 & ~clr1) | set1);
        nxt_st.sr2 = isf_sr2_type'((st_ff.sr2 & ~clr2) | set2);
        nxt_st.sr2.zero = '0;                                                    // R13

        // Remember the kind of byte so the right data access clears it
        if (set1.byte_done) begin
            nxt_st.bd_tx = set1.sending_side;
        end
        // Failure may only be read away once the acknowledge pulse fell
        if (!nxt_st.sr2.ack_failure) begin
            nxt_st.af_fall_ok = 1'b0;
        end else if (scl_fall) begin
            nxt_st.af_fall_ok = 1'b1;                                            // R15
        end
        // Two-step marker: any new event in between cancels it
        if (rd_dr || wr_dr) begin
            nxt_st.rd1_armed = 1'b0;
        end else if (rd_sr1) begin
            nxt_st.rd1_armed = 1'b1;                                             // R22
        end else if (|set1 || |set2) begin
            nxt_st.rd1_armed = 1'b0;                                             // R22
        end

        // Disabled unit keeps nothing but the busy tracking
        if (!st_ff.ctrl.unit_on) begin
            nxt_st.sr1        = '0;                                              // R21
            nxt_st.sr2        = '0;                                              // R21
            nxt_st.rd1_armed  = 1'b0;
            nxt_st.bd_tx      = 1'b0;
            nxt_st.af_fall_ok = 1'b0;
        end
        if (start_det) begin
            nxt_st.sr1.bus_busy = 1'b1;                                          // R5
        end else if (stop_det) begin
            nxt_st.sr1.bus_busy = 1'b0;                                          // R5
        end else begin
            nxt_st.sr1.bus_busy = st_ff.sr1.bus_busy;
        end
        nxt_st.sr1.event_pending = nxt_st.sr1.byte_done | nxt_st.sr1.slave_addr_match
            | nxt_st.sr1.start_sent | nxt_st.sr1.ten_bit_header_sent
            | nxt_st.sr2.addr_acked_master | nxt_st.sr2.ack_failure
            | nxt_st.sr2.stop_seen | nxt_st.sr2.arb_lost | nxt_st.sr2.bus_error; // R1 R2

        // Request only for events not swallowed by a clearing read
        nxt_st.event_req = st_ff.ctrl.irq_enable
            & ((|set1 & ~rd_sr1) | (|set2 & ~rd_sr2));                           // R12
        // Stretch only for flags that hold the bus; error flags never do
        nxt_st.scl_oe_n = ~(nxt_st.sr1.byte_done | nxt_st.sr1.slave_addr_match
            | nxt_st.sr1.start_sent | nxt_st.sr1.ten_bit_header_sent
            | nxt_st.sr2.addr_acked_master);                                     // R8 R9 R11

        // Control register and its hardware clears
        if (wr_cr && s_axi_wstrb[0]) begin
            nxt_st.ctrl      = isf_ctrl_type'(s_axi_wdata[7:0]);
            nxt_st.ctrl.zero = '0;
        end
        if (eng_i.start_gen) begin
            nxt_st.ctrl.start_req = 1'b0;
        end
        if (stop_det && st_ff.sr1.master_active) begin
            nxt_st.ctrl.stop_req = 1'b0;
        end
        if (!nxt_st.ctrl.unit_on) begin
            nxt_st.ctrl.general_call_enable = 1'b0;
            nxt_st.ctrl.start_req           = 1'b0;
            nxt_st.ctrl.ack_enable          = 1'b0;
            nxt_st.ctrl.irq_enable          = 1'b0;
        end
        nxt_st.tx_load = wr_dr;
        if (wr_dr) begin
            nxt_st.tx_data = s_axi_wdata[7:0];
        end

        // Write channel
        nxt_st.awready = 1'b0;
        nxt_st.wready  = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && !st_ff.awready && !st_ff.bvalid) begin
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end
        if (wr_go) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = wr_hit ? ISF_RESP_OKAY : ISF_RESP_SLVERR;
        end else if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // Read channel; status reads clear flags on the taking edge
        unique case (1'b1)
            rd_sr1:  rbyte = st_ff.sr1;
            rd_sr2:  rbyte = st_ff.sr2;                                          // R13
            rd_dr:   rbyte = eng_i.rx_byte;
            default: rbyte = st_ff.ctrl;
        endcase
        nxt_st.arready = 1'b0;
        if (s_axi_arvalid && !st_ff.arready && !st_ff.rvalid) begin
            nxt_st.arready = 1'b1;
        end
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = rd_hit ? ISF_RESP_OKAY : ISF_RESP_SLVERR;
            nxt_st.rdata  = rd_hit ? {24'h000000, rbyte} : 32'h00000000;
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff          <= '0;
            st_ff.scl_s1   <= 1'b1;
            st_ff.scl_s2   <= 1'b1;
            st_ff.scl_d    <= 1'b1;
            st_ff.sda_s1   <= 1'b1;
            st_ff.sda_s2   <= 1'b1;
            st_ff.sda_d    <= 1'b1;
            st_ff.scl_oe_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops; SCL is only ever pulled low
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rresp   = st_ff.rresp;
    assign s_axi_rdata   = st_ff.rdata;
    assign scl_o         = 1'b0;
    assign scl_oe_n_o    = st_ff.scl_oe_n;
    assign ctrl_o        = st_ff.ctrl;
    assign tx_data_o     = st_ff.tx_data;
    assign tx_load_o     = st_ff.tx_load;
    assign event_req_o   = st_ff.event_req;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sr1_read;
        rd_sr1 && !(|set1);
    endsequence
    sequence s_dr_write;
        wr_dr && !(|set1) && !(|set2);
    endsequence

    evp_summary_a: assert property ( // R1
        st_ff.sr1.event_pending == (st_ff.sr1.byte_done | st_ff.sr2.arb_lost
        | st_ff.sr1.start_sent | st_ff.sr2.ack_failure | st_ff.sr2.bus_error
        | st_ff.sr1.slave_addr_match | st_ff.sr2.stop_seen
        | st_ff.sr1.ten_bit_header_sent | st_ff.sr2.addr_acked_master))
        else $error("event flag disagrees with its sources");
    busy_set_a: assert property ( // R5
        start_det |=> st_ff.sr1.bus_busy)
        else $error("busy flag not set by Start");
    busy_clear_a: assert property ( // R5
        stop_det |=> !st_ff.sr1.bus_busy)
        else $error("busy flag not cleared by Stop");
    // The read and the write may lie many cycles apart; the marker links them
    tx_two_step_a: assert property ( // R6
        st_ff.sr1.byte_done && st_ff.bd_tx && st_ff.rd1_armed ##0 s_dr_write
        |=> !st_ff.sr1.byte_done)
        else $error("transmit byte flag survived two-step clear");
    armed_set_a: assert property ( // R22
        s_sr1_read ##0 (!wr_dr && st_ff.ctrl.unit_on) |=> st_ff.rd1_armed)
        else $error("status read did not arm the marker");
    scl_stretch_a: assert property ( // R8
        st_ff.sr1.byte_done |-> !st_ff.scl_oe_n)
        else $error("SCL released while byte flag set");
    slave_addr_match_clear_a: assert property ( // R9
        rd_sr1 && st_ff.ctrl.unit_on && !set1.slave_addr_match |=> !st_ff.sr1.slave_addr_match)
        else $error("address flag not cleared by status read");
    no_req_read_a: assert property ( // R12
        rd_sr2 && !(|set1) |=> !st_ff.event_req)
        else $error("request raised for flag cleared by read");
    sr2_top_zero_a: assert property ( // R13
        st_ff.rvalid && $past(rd_sr2) && $rose(st_ff.rvalid) |-> st_ff.rdata[7:6] == 2'h0)
        else $error("status two top bits not zero");
    misplaced_start_a: assert property ( // R19
        st_ff.ctrl.unit_on && start_det && eng_i.in_byte |=> st_ff.sr2.bus_error
        && st_ff.sr2.arb_lost && !st_ff.sr1.master_active)
        else $error("misplaced Start flags wrong");
    disable_clear_a: assert property ( // R21
        !st_ff.ctrl.unit_on |=> st_ff.sr2 == '0 && st_ff.sr1.byte_done == 1'b0
        && st_ff.sr1.event_pending == 1'b0 && st_ff.scl_oe_n)
        else $error("flags kept while disabled");
    armed_cancel_a: assert property ( // R22
        st_ff.rd1_armed && !rd_sr1 && !rd_dr && !wr_dr && (|set2) |=> !st_ff.rd1_armed)
        else $error("marker survived intervening event");

endmodule : isf_status

`default_nettype wire

// ### tb/isf_bus_model.sv
`default_nettype none

module isf_bus_model (
    input  wire logic scl_oe_n,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ns;

    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;

    // ------------------------------------------------------------
    // Wired-AND clock line, data line driven by the model alone; both high when released
    // ------------------------------------------------------------
    assign scl = scl_drv & scl_oe_n;
    assign sda = sda_drv;

    // Start: data falls while the clock is high, half a 400 ns period each
    task automatic start_c();
        sda_drv = 1'b0;
        #200;
        scl_drv = 1'b0;
        #200;
    endtask : start_c

    // Stop: clock released first so the data rise lands in the high phase
    task automatic stop_c();
        sda_drv = 1'b0;
        #200;
        scl_drv = 1'b1;
        #200;
        sda_drv = 1'b1;
        #200;
    endtask : stop_c

endmodule : isf_bus_model

`default_nettype wire

// ### tb/isf_status_bench.sv
`default_nettype none

module isf_status_bench
    import isf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [11:0] A_CTRL = {2'b0, ISF_IDX_CTRL, 2'b0};
    localparam logic [11:0] A_SR1  = {2'b0, ISF_IDX_SR1, 2'b0};
    localparam logic [11:0] A_SR2  = {2'b0, ISF_IDX_SR2, 2'b0};
    localparam logic [11:0] A_DATA = {2'b0, ISF_IDX_DATA, 2'b0};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awv, wv, brd, arv, rrd, awr, wr, bv, arr, rv, oe_n, scl, sda;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr;
    logic [20:0] engv = '0;
    logic        evq;
    logic [7:0]  txd;
    int          evn = 0;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;

    isf_status isf_status_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
        .eng_i(isf_eng_type'(engv)), .scl_i(scl), .sda_i(sda),
        .scl_o(), .scl_oe_n_o(oe_n), .ctrl_o(), .tx_data_o(txd), .tx_load_o(),
        .event_req_o(evq)
    );

    isf_bus_model isf_bus_model_i (.scl_oe_n(oe_n), .scl(scl), .sda(sda));

    // ------------------------------------------------------------
    // Clock and hang guard; the run needs well under a thousand cycles
    // ------------------------------------------------------------
    initial forever #25 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Count event requests; each stands for exactly one cycle
    always @(posedge aclk) begin
        if (evq === 1'b1) begin
            evn <= evn + 1;
        end
    end

    // ------------------------------------------------------------
    // Expectation, compare and bus tasks
    // ------------------------------------------------------------
    // Event flag is the OR of every event-type flag of both registers
    function automatic logic [7:0] exp1(input logic [7:0] f1, input logic [7:0] f2);
        return f1 | {(|(f1 & 8'h4d)) | (|(f2 & 8'h3e)), 7'h0};
    endfunction : exp1

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic wchk(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        @(posedge aclk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        do @(posedge aclk); while (awr !== 1'b1 || wr !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge aclk); while (bv !== 1'b1);
        brd <= 1'b0;
        chk(br, e);
    endtask : wchk

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        rrd <= 1'b0;
        d = rd;
        r = rr;
    endtask : rd_reg

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd_reg(a, d, r);
        chk(d, {24'h0, e});
    endtask : rchk

    // One-cycle engine pulse; the received byte stays on afterwards
    task automatic pulse(input logic [20:0] v);
        @(posedge aclk);
        engv <= v;
        @(posedge aclk);
        engv <= v & 21'hff;
        repeat (2) @(posedge aclk);
    endtask : pulse

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  x;
        {awv, wv, brd, arv, rrd} = '0;
        {awa, ara, wd} = '0;
        x = 8'($urandom(20));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(A_SR1, 8'h00);
        rchk(A_SR2, 8'h00);
        bus_i_start: begin
            isf_bus_model_i.start_c();
            repeat (6) @(posedge aclk);
            rchk(A_SR1, 8'h10);
            isf_bus_model_i.stop_c();
            repeat (6) @(posedge aclk);
            rchk(A_SR1, 8'h00);
        end
        $display("test busy done");
        wchk(A_CTRL, 8'h2d, ISF_RESP_OKAY);
        pulse(21'h1 << 16);
        chk(oe_n, 1'b0);
        chk(scl, 1'b0);
        rchk(A_SR1, exp1(8'h03, 8'h00));
        wchk(A_DATA, x, ISF_RESP_OKAY);
        rchk(A_SR1, 8'h02);
        // Header set between read and write must cancel the pending clear
        pulse(21'h1 << 20);
        rchk(A_SR1, exp1(8'h2a, 8'h00));
        pulse(21'h1 << 15);
        wchk(A_DATA, x, ISF_RESP_OKAY);
        rchk(A_SR1, exp1(8'h6a, 8'h00));
        wchk(A_DATA, x, ISF_RESP_OKAY);
        chk(txd, x);
        rchk(A_SR1, 8'h02);
        $display("test transmit done");
        for (int i = 0; i < 4; i++) begin
            x = 8'($urandom);
            pulse((21'h1 << 19) | 21'(x));
            rchk(A_SR1, exp1(8'h0a, 8'h00));
            rchk(A_DATA, x);
            rchk(A_SR1, 8'h02);
        end
        $display("test receive done");
        pulse(21'h1 << 12);
        rchk(A_SR1, exp1(8'h00, 8'h04));
        rchk(A_SR2, 8'h04);
        rchk(A_SR2, 8'h00);
        rchk(A_SR1, 8'h00);
        rd_reg(12'h100, d, r);
        chk(r, ISF_RESP_SLVERR);
        wchk(A_SR1, 8'hff, ISF_RESP_OKAY);
        $display("test arbitration done");
        // Start and Stop inside a byte: bus error, the Start also loses arbitration
        @(posedge aclk);
        engv <= 21'h1 << 9;
        isf_bus_model_i.start_c();
        repeat (6) @(posedge aclk);
        isf_bus_model_i.stop_c();
        repeat (6) @(posedge aclk);
        engv <= '0;
        rchk(A_SR1, exp1(8'h00, 8'h06));
        rchk(A_SR2, 8'h06);
        $display("test bus error done");
        pulse(21'h1 << 18);
        pulse(21'h1 << 13);
        chk(oe_n, 1'b0);
        wchk(A_CTRL, 8'h00, ISF_RESP_OKAY);
        repeat (2) @(posedge aclk);
        rchk(A_SR1, 8'h00);
        rchk(A_SR2, 8'h00);
        $display("test disable done");
        // One request per engine event and per misplaced condition while enabled
        chk(evn, 12);
        report_and_stop();
    end

endmodule : isf_status_bench

`default_nettype wire
